// ### mrs_slave.sv
/*
  serial register-access slave: receives framed requests, accesses the
  parameter store and sends framed answers on a half-duplex line.
  assumes rx_i from a pin, a line driver switched by tx_en_o, and a parameter
  store on the same clock answering par_req_o with a one-cycle ack.
*/
`timescale 1ns/1ps
// Function
// - start, 8 data lsb first, two stops
// - eleven selectable rates 300 to 115200
// - address, function, data, crc, then silence
// - 3.5 idle characters end a frame
// - frame bytes sent back to back
// - bad crc frames are dropped silently
// - answer within max time, after silence
// - node addresses 1 to 247
// - broadcast accepted, never answered
// - register index spans 14 bits
// - every parameter is a holding register
// - index plus one gives menu, parameter
// - address bit 14 selects 32-bit access, except for code 6
// - address bit 15 has no meaning
// - 32-bit value is two words, msw first
// - 16-bit read returns low word
// - 32-bit read sign-extends 16-bit parameter
// - data msb first, crc lsb first
// - codes 3, 6, 16, 23; bit7 flags exception
// - reads over 16 registers get code 2
// - 16-bit write is sign-extended
module mrs_slave
  import mrs_pkg::*;
#(
  parameter int unsigned BUF_BYTES = 48,
  parameter int unsigned MAX_REGS  = 16,
  parameter int unsigned RESP_CYC  = RESP_MAX_CYC
)(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       rx_i,
  input  wire logic [7:0] node_addr_i,
  input  wire logic [3:0] baud_sel_i,
  input  wire mrs_rsp_t   par_rsp_i,
  output logic            tx_o,
  output logic            tx_en_o,
  output logic            par_req_o,
  output mrs_par_t        par_o
);

  // refuse sizes the pointers or buffer cannot hold
  if (BUF_BYTES > 63 || BUF_BYTES < LEN_RW_OVH + 2 * MAX_REGS || MAX_REGS > 31) begin : g_bad
    $error("mrs_slave: buffer or register limit out of range");
  end

  // whole block state
  typedef struct packed {
    logic                       rx_meta;   // first sync stage
    logic                       rx_sync;   // second sync stage
    logic                       rx_prev;   // for start edge
    logic                       rx_busy;
    logic [19:0]                rx_cnt;
    logic [3:0]                 rx_bit;
    logic [7:0]                 rx_sh;
    logic [19:0]                tk_cnt;    // bit tick divider
    logic [5:0]                 sil;       // idle bit ticks
    mrs_st_t                    st;
    logic [BUF_BYTES-1:0][7:0]  buff;      // frame in, answer out
    logic [5:0]                 len;
    logic [5:0]                 ptr;
    logic [5:0]                 rd_ptr;    // write data source
    logic [5:0]                 wr_ptr;    // read data sink
    logic                       ovf;
    logic [15:0]                crc;
    logic                       bcast;
    logic                       is32;
    logic                       wr;
    logic                       rd_pend;   // read phase still to do
    logic [15:0]                rd_start;
    logic [15:0]                rd_cnt;
    logic [13:0]                op_idx;
    logic [4:0]                 op_left;
    logic [7:0]                 exc;
    logic [31:0]                tmr;
    logic                       tx_busy;
    logic [19:0]                tx_cnt;
    logic [3:0]                 tx_bit;
    logic [10:0]                tx_sh;
    logic                       tx_en;
    logic                       par_req;
    mrs_par_t                   par;
  } mrs_state_t;

  mrs_state_t s;        // registered state
  mrs_state_t n;        // next state
  logic       rx_done;  // byte with valid stop bit
  logic [15:0] c_rd;    // read count as received

  // cycles per bit for the selected rate
  // eleven selectable rates
  function automatic logic [19:0] bit_div(input logic [3:0] sel);
    return (sel <= BAUD_MAX) ? BIT_DIV[sel] : BIT_DIV[BAUD_DEF];
  endfunction

  // exception for a register count, zero if fine
  function automatic logic [7:0] cnt_chk(input logic [15:0] c, input logic m32);
    if (c == 16'h0000) return EXC_VAL;
    if (c > 16'(MAX_REGS)) return EXC_ADDR;
    if (m32 && c[0]) return EXC_VAL;
    return 8'h00;
  endfunction

  // parameters covered by a register count
  function automatic logic [4:0] n_par(input logic [15:0] c, input logic m32);
    return m32 ? c[5:1] : c[4:0];
  endfunction

  // next state
  always_comb begin
    logic [19:0] div;
    logic [14:0] idx;
    logic [31:0] rv;
    logic [15:0] a0;
    logic [15:0] c0;
    logic [15:0] a1;
    logic [15:0] c1;
    logic [5:0]  rp;
    logic [5:0]  wp;
    n = s;
    rx_done = 1'b0;
    div = bit_div(baud_sel_i);
    idx = {1'b0, s.op_idx} + 15'h0001;
    rv = 32'h0000_0000;
    a0 = {s.buff[2], s.buff[3]};
    c0 = {s.buff[4], s.buff[5]};
    a1 = {s.buff[6], s.buff[7]};
    c1 = {s.buff[8], s.buff[9]};
    rp = s.rd_ptr;
    wp = s.wr_ptr;
    // pin synchroniser
    n.rx_meta = rx_i;
    n.rx_sync = s.rx_meta;
    n.rx_prev = s.rx_sync;
    // free bit tick
    n.tk_cnt = (s.tk_cnt == 20'h0) ? div - 20'h1 : s.tk_cnt - 20'h1;
    if (!s.rx_busy) begin
      if (s.rx_prev && !s.rx_sync) begin
        n.rx_busy = 1'b1;
        n.rx_cnt = div >> 1;
        n.rx_bit = 4'h0;
      end
    end else if (s.rx_cnt != 20'h0) begin
      n.rx_cnt = s.rx_cnt - 20'h1;
    end else begin
      n.rx_cnt = div - 20'h1;
      n.rx_bit = s.rx_bit + 4'h1;
      if (s.rx_bit == 4'h0 && s.rx_sync) begin
        n.rx_busy = 1'b0;                 // glitch, not a start bit
      end else if (s.rx_bit == STOP_RX) begin
        n.rx_busy = 1'b0;
        rx_done = s.rx_sync;              // framing error drops the byte
      end else if (s.rx_bit != 4'h0) begin
        n.rx_sh = {s.rx_sync, s.rx_sh[7:1]};
      end
    end
    if (s.rx_busy || !s.rx_sync) begin
      n.sil = 6'h00;
    end else if (s.tk_cnt == 20'h0 && s.sil != SIL_TICKS) begin
      n.sil = s.sil + 6'h01;
    end
    case (s.st)
      // collect bytes until the line falls silent
      S_RX: begin
        if (rx_done) begin
          if (s.len < 6'(BUF_BYTES)) begin
            n.buff[s.len] = s.rx_sh;
            n.len = s.len + 6'h01;
            n.crc = crc_upd(s.crc, s.rx_sh);
          end else begin
            n.ovf = 1'b1;
          end
        end else if (s.len != 6'h00 && s.sil == SIL_TICKS) begin
          n.st = S_EXEC;
        end
      end
      // check and decode the request
      S_EXEC: begin
        n.st = S_RX;
        n.len = 6'h00;
        n.crc = CRC_INIT;
        n.ovf = 1'b0;
        if (s.crc == 16'h0000 && !s.ovf && s.len >= LEN_MIN &&
            (s.buff[0] == ADDR_BCAST ||
             (s.buff[0] == node_addr_i && node_addr_i <= NODE_MAX))) begin
          n.st = S_ACC;
          n.bcast = (s.buff[0] == ADDR_BCAST);
          n.exc = 8'h00;
          n.rd_pend = 1'b0;
          n.tmr = 32'h0;
          n.wr_ptr = OFS_RDAT;
          // bit 14 picks width, bit 15 ignored
          n.is32 = a0[MODE32_BIT];
          n.op_idx = a0[13:0];
          n.wr = 1'b1;
          case (s.buff[1])
            FC_RD: begin
              n.wr = 1'b0;
              n.exc = cnt_chk(c0, a0[MODE32_BIT]);
              n.op_left = n_par(c0, a0[MODE32_BIT]);
            end
            FC_WR1: begin
              n.is32 = 1'b0;
              n.op_left = 5'h01;
              n.rd_ptr = OFS_CNT;
            end
            FC_WRN: begin
              n.exc = cnt_chk(c0, a0[MODE32_BIT]);
              n.op_left = n_par(c0, a0[MODE32_BIT]);
              n.rd_ptr = OFS_DAT16;
            end
            FC_RW: begin
              // writes first, then the read phase
              n.is32 = a1[MODE32_BIT];
              n.op_idx = a1[13:0];
              n.exc = cnt_chk(c1, a1[MODE32_BIT]);
              if (n.exc == 8'h00) begin
                n.exc = cnt_chk(c0, a0[MODE32_BIT]);
              end
              n.op_left = n_par(c1, a1[MODE32_BIT]);
              n.rd_pend = 1'b1;
              n.rd_start = a0;
              n.rd_cnt = c0;
              n.rd_ptr = OFS_DAT23;
            end
            default: begin
              n.exc = EXC_FUNC;
            end
          endcase
        end
      end
      // walk the parameters one by one
      S_ACC: begin
        n.tmr = s.tmr + 32'h1;
        if (s.exc != 8'h00) begin
          n.par_req = 1'b0;
          n.buff[1] = s.buff[1] | EXC_FLAG;
          n.buff[2] = s.exc;
          n.len = LEN_EXC;
          n.ptr = 6'h00;
          n.crc = CRC_INIT;
          n.st = S_CRC;
          if (s.bcast) begin
            n.st = S_RX;
            n.len = 6'h00;
          end
        end else if (s.tmr >= RESP_CYC) begin
          // store too slow, answer in time with failure
          n.exc = EXC_FAIL;
        end else if (s.op_left == 5'h00) begin
          if (s.rd_pend) begin
            n.rd_pend = 1'b0;
            n.wr = 1'b0;
            n.is32 = s.rd_start[MODE32_BIT];
            n.op_idx = s.rd_start[13:0];
            n.op_left = n_par(s.rd_cnt, s.rd_start[MODE32_BIT]);
          end else begin
            n.len = LEN_ECHO;
            if (!s.wr) begin
              n.buff[2] = {2'b00, s.wr_ptr - OFS_RDAT};
              n.len = s.wr_ptr;
            end
            n.ptr = 6'h00;
            n.crc = CRC_INIT;
            n.st = S_CRC;
            if (s.bcast) begin
              n.st = S_RX;
              n.len = 6'h00;
            end
          end
        end else if (!s.par_req) begin
          // index plus one splits into menu and parameter
          if (idx / MENU_STRIDE > MENU_MAX) begin
            n.exc = EXC_ADDR;
          end else begin
            // every access is a holding register access
            n.par_req = 1'b1;
            n.par.we = s.wr;
            n.par.menu_index = 7'(idx / MENU_STRIDE);
            n.par.num = 7'(idx % MENU_STRIDE);
            n.par.wdata = s.is32 ? {s.buff[rp], s.buff[rp + 6'h01], s.buff[rp + 6'h02], s.buff[rp + 6'h03]}
                                 : {{16{s.buff[rp][7]}}, s.buff[rp], s.buff[rp + 6'h01]};
          end
        end else if (par_rsp_i.ack) begin
          n.par_req = 1'b0;
          n.op_idx = s.op_idx + 14'h0001;
          n.op_left = s.op_left - 5'h01;
          if (s.wr) begin
            n.rd_ptr = s.rd_ptr + (s.is32 ? 6'h04 : 6'h02);
          end else if (s.is32) begin
            rv = par_rsp_i.is32 ? par_rsp_i.rdata
                                : {{16{par_rsp_i.rdata[15]}}, par_rsp_i.rdata[15:0]};
            n.buff[wp] = rv[31:24];
            n.buff[wp + 6'h01] = rv[23:16];
            n.buff[wp + 6'h02] = rv[15:8];
            n.buff[wp + 6'h03] = rv[7:0];
            n.wr_ptr = s.wr_ptr + 6'h04;
          end else begin
            n.buff[wp] = par_rsp_i.rdata[15:8];
            n.buff[wp + 6'h01] = par_rsp_i.rdata[7:0];
            n.wr_ptr = s.wr_ptr + 6'h02;
          end
        end
      end
      S_CRC: begin
        if (s.ptr != s.len) begin
          n.crc = crc_upd(s.crc, s.buff[s.ptr]);
          n.ptr = s.ptr + 6'h01;
        // never earlier than the silent interval
        end else if (s.sil == SIL_TICKS) begin
          n.buff[s.len] = s.crc[7:0];
          n.buff[s.len + 6'h01] = s.crc[15:8];
          n.len = s.len + 6'h02;
          n.ptr = 6'h00;
          n.tx_en = 1'b1;
          n.st = S_SEND;
        end
      end
      // send the answer
      S_SEND: begin
        if (s.tx_busy) begin
          if (s.tx_cnt != 20'h0) begin
            n.tx_cnt = s.tx_cnt - 20'h1;
          end else begin
            n.tx_cnt = div - 20'h1;
            n.tx_sh = {1'b1, s.tx_sh[10:1]};
            n.tx_bit = s.tx_bit + 4'h1;
            if (s.tx_bit == LAST_BIT) begin
              n.tx_busy = 1'b0;
            end
          end
        // next byte at once, two stops
        end else if (s.ptr != s.len) begin
          n.tx_sh = {2'b11, s.buff[s.ptr], 1'b0};
          n.tx_busy = 1'b1;
          n.tx_cnt = div - 20'h1;
          n.tx_bit = 4'h0;
          n.ptr = s.ptr + 6'h01;
        end else begin
          n.tx_en = 1'b0;
          n.len = 6'h00;
          n.crc = CRC_INIT;
          n.st = S_RX;
        end
      end
      default: begin
        n.st = S_RX;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.rx_meta <= 1'b1;
      s.rx_sync <= 1'b1;
      s.rx_prev <= 1'b1;
      s.crc <= CRC_INIT;
      s.tx_sh <= TX_IDLE;
    end else begin
      s <= n;
    end
  end

  // outputs straight from flops
  assign tx_o = s.tx_sh[0];
  assign tx_en_o = s.tx_en;
  assign par_req_o = s.par_req;
  assign par_o = s.par;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_two_stops: assert property (s.tx_busy && s.tx_bit >= STOP_RX |-> tx_o)
    else $error("stop bit not high");
  chk_frame_end: assert property (s.st == S_RX && !rx_done && s.len != 6'h00 && s.sil == SIL_TICKS
    |=> s.st == S_EXEC)
    else $error("silence did not end frame");
  chk_back_to_back: assert property (s.st == S_SEND && !s.tx_busy && s.ptr != s.len |=> s.tx_busy)
    else $error("gap between bytes");
  chk_crc_drop: assert property (s.st == S_EXEC && s.crc != 16'h0000 |=> s.st == S_RX ##1 !par_req_o)
    else $error("bad frame acted on");
  chk_resp_gap: assert property ($rose(tx_en_o) |-> $past(s.sil) == SIL_TICKS)
    else $error("answer before silence");
  chk_resp_time: assert property (s.st == S_ACC |-> s.tmr <= RESP_CYC + 1)
    else $error("answer too late");
  chk_bcast_quiet: assert property (s.bcast |-> !tx_en_o)
    else $error("broadcast answered");
  chk_menu_range: assert property (par_req_o |-> par_o.menu_index <= 7'(MENU_MAX) && par_o.num <= 7'(MENU_MAX))
    else $error("parameter index out of range");
  chk_exc_flag: assert property (s.st == S_CRC && s.exc != 8'h00 |-> s.buff[1][7] && s.len >= LEN_EXC)
    else $error("exception without flag");
  chk_read_limit: assert property (s.st == S_ACC && $past(s.st) == S_EXEC && s.buff[1] == FC_RD &&
    c_rd > 16'(MAX_REGS) |-> s.exc == EXC_ADDR)
    else $error("read limit not refused");
  chk_sign_ext: assert property (par_req_o && par_o.we && !s.is32
    |-> par_o.wdata[31:16] == {16{par_o.wdata[15]}})
    else $error("16-bit write not sign-extended");

  // read count as received, for the limit check; read data overwrites it later
  assign c_rd = {s.buff[4], s.buff[5]};

endmodule

// ### mrs_pkg.sv
/*
  shared constants, carriers and helpers of the serial register-access slave.
  assumes a single 100 MHz device clock; everything else is derived from it.
*/
package mrs_pkg;
  // device clock rate in Hz
  localparam int unsigned CLK_HZ = 100_000_000;
  // clock cycles per bit for rate select codes 0 to 10
  localparam logic [19:0] BIT_DIV [0:10] = '{
    20'(CLK_HZ / 300), 20'(CLK_HZ / 600), 20'(CLK_HZ / 1200), 20'(CLK_HZ / 2400),
    20'(CLK_HZ / 4800), 20'(CLK_HZ / 9600), 20'(CLK_HZ / 19200), 20'(CLK_HZ / 38400),
    20'(CLK_HZ / 57600), 20'(CLK_HZ / 76800), 20'(CLK_HZ / 115200)};
  localparam logic [3:0] BAUD_MAX = 4'hA;         // highest rate code
  localparam logic [3:0] BAUD_DEF = 4'h5;         // unknown codes fall back here
  // character: start, 8 data, 2 stop
  localparam int unsigned CHAR_BITS = 11;
  localparam logic [3:0] LAST_BIT = 4'(CHAR_BITS - 1);
  localparam logic [3:0] STOP_RX  = 4'h9;         // first stop bit sample
  // end of frame silence in characters, counted in bit ticks from the first stop sample;
  // plus two: the 1.5 bits of the last character still on the line and the tick phase
  localparam real SIL_CHARS = 3.5;
  localparam logic [5:0] SIL_TICKS = 6'(int'($ceil(SIL_CHARS * CHAR_BITS)) + 2);
  // longest wait from frame end to response start
  localparam int unsigned RESP_MAX_US  = 10_000;
  localparam int unsigned RESP_MAX_CYC = RESP_MAX_US * (CLK_HZ / 1_000_000);
  // frame fields
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] NODE_MAX   = 8'hF7;
  localparam logic [7:0] FC_RD  = 8'h03;
  localparam logic [7:0] FC_WR1 = 8'h06;
  localparam logic [7:0] FC_WRN = 8'h10;
  localparam logic [7:0] FC_RW  = 8'h17;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VAL  = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;
  localparam logic [5:0] OFS_CNT   = 6'h04;       // count, or data of single write
  localparam logic [5:0] OFS_DAT16 = 6'h07;       // write-multiple data
  localparam logic [5:0] OFS_DAT23 = 6'h0B;       // read/write data
  localparam logic [5:0] OFS_RDAT  = 6'h03;       // read data in response
  localparam logic [5:0] LEN_ECHO  = 6'h06;
  localparam logic [5:0] LEN_EXC   = 6'h03;
  localparam logic [5:0] LEN_MIN   = 6'h04;
  localparam int unsigned LEN_RW_OVH = 13;        // longest request overhead
  localparam int unsigned MODE32_BIT = 14;
  localparam logic [14:0] MENU_STRIDE = 15'h0064;
  localparam logic [14:0] MENU_MAX    = 15'h0063;
  // crc reset value and polynomial, idle value after reset
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [10:0] TX_IDLE  = 11'h7FF;

  // parameter store request
  typedef struct packed {
    logic        we;
    logic [6:0]  menu_index;
    logic [6:0]  num;
    logic [31:0] wdata;
  } mrs_par_t;
  // parameter store answer
  typedef struct packed {
    logic        ack;
    logic        is32;
    logic [31:0] rdata;
  } mrs_rsp_t;

  typedef enum logic [2:0] {
    S_RX   = 3'b000,
    S_EXEC = 3'b001,
    S_ACC  = 3'b010,
    S_CRC  = 3'b011,
    S_SEND = 3'b100
  } mrs_st_t;

  // one byte step of the reflected frame crc
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ### mrs_master_model.sv
/*
  serial bus master model: sends framed requests and collects answer bytes.
  assumes a 100 MHz clock and the slave set to 115200 baud.
*/
`timescale 1ns/1ps
module mrs_master_model (
  input  wire logic ref_clk_i,
  input  wire logic line_i,    // slave serial out
  input  wire logic drv_en_i,  // slave line driver enable
  output logic      line_o     // slave serial in, idle high
);
  localparam int BIT = 868;    // cycles per bit at 115200
  logic [7:0] rx_q[$];         // answer bytes seen
  logic       stop_ok = 1'b1;  // all stop bits high
  logic       en_d = 1'b0;     // delayed driver enable
  int         cyc = 0;         // free cycle count
  int         end_cyc = 0;     // cycle of request end
  int         rise_cyc = 0;    // cycle of answer start
  initial line_o = 1'b1;

  // reflected frame check over a byte list
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  // start, data lsb first, two stops
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge ref_clk_i);
      #1;
      line_o = f[i];
      repeat (BIT - 1) @(posedge ref_clk_i);
    end
  endtask

  // bytes back to back, check low byte first
  task automatic send_frame(input logic [7:0] q[$], input logic bad_crc);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad_crc};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) send_byte(q[i]);
    end_cyc = cyc;
  endtask

  // cycle count and answer start time
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    en_d <= drv_en_i;
    if (drv_en_i && !en_d) begin
      rise_cyc <= cyc;
    end
  end

  always begin
    logic [7:0] b;
    @(negedge line_i iff drv_en_i);
    repeat (BIT / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk_i);
      b[i] = line_i;
    end
    repeat (2) begin
      repeat (BIT) @(posedge ref_clk_i);
      stop_ok = stop_ok & line_i;
    end
    rx_q.push_back(b);
  end
endmodule

// ### test_mrs_slave.sv
/*
  self-checking testbench of the serial register-access slave.
  assumes the master model and a store that acks each access in one cycle.
*/
`timescale 1ns/1ps
module test_mrs_slave
  import mrs_pkg::*;
;
  localparam int BIT   = 868;                  // cycles per bit
  localparam int RESP  = 2000;                 // short store timeout
  localparam int T_MIN = 33418;                // 3.5 characters
  localparam int T_MAX = 41 * BIT + RESP + 500;
  logic     ref_clk_i = 1'b0;                  // 100 MHz clock
  logic     rst_i = 1'b1;                      // reset, high
  logic     rx_line;                           // master to slave
  mrs_rsp_t par_rsp_i = '0;                    // store answer
  logic     tx_o;
  logic     tx_en_o;
  logic     par_req_o;
  mrs_par_t par_o;
  mrs_par_t par_log[$];                        // accesses seen
  int       fail_count = 0;
  int       total_checks = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  mrs_slave #(.RESP_CYC(RESP)) i_mrs_slave (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .rx_i        (rx_line),
    .node_addr_i (8'h01),
    .baud_sel_i  (BAUD_MAX),
    .par_rsp_i   (par_rsp_i),
    .tx_o        (tx_o),
    .tx_en_o     (tx_en_o),
    .par_req_o   (par_req_o),
    .par_o       (par_o)
  );

  mrs_master_model i_mrs_master_model (
    .ref_clk_i (ref_clk_i),
    .line_i    (tx_o),
    .drv_en_i  (tx_en_o),
    .line_o    (rx_line)
  );

  // store model: log each access, ack it once
  always @(posedge ref_clk_i) begin
    #1;
    if (par_req_o && !par_rsp_i.ack) begin
      par_log.push_back(par_o);
      par_rsp_i.ack = 1'b1;
    end else begin
      par_rsp_i.ack = 1'b0;
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // the only access: write flag, menu, parameter
  task automatic chk_acc(input logic [14:0] exp);
    chk_val(par_log.size(), 1, "access count");
    chk_val({17'h0, par_log[0].we, par_log[0].menu_index, par_log[0].num}, {17'h0, exp}, "access target");
  endtask

  // bounded wait for a whole answer, then bytes and delay
  task automatic expect_resp(input logic [7:0] e[$]);
    logic [15:0] c;
    int          n;
    int          lat;
    c = i_mrs_master_model.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    n = 0;
    while ((i_mrs_master_model.rx_q.size() < e.size() || tx_en_o !== 1'b0) && n < 200000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk_val({31'h0, n < 200000}, 32'h1, "answer timeout");
    lat = i_mrs_master_model.rise_cyc - i_mrs_master_model.end_cyc;
    chk_val(i_mrs_master_model.rx_q.size(), e.size(), "answer length");
    foreach (e[i]) chk_val(i_mrs_master_model.rx_q[i], e[i], "answer byte");
    chk_val({31'h0, i_mrs_master_model.stop_ok}, 32'h1, "stop bits");
    chk_val({31'h0, lat >= T_MIN && lat <= T_MAX}, 32'h1, "answer delay");
    i_mrs_master_model.rx_q.delete();
    repeat (2 * BIT) @(posedge ref_clk_i);
  endtask

  // a full response window passes with the line untouched
  task automatic expect_none();
    int r;
    r = i_mrs_master_model.rise_cyc;
    repeat (T_MAX) @(posedge ref_clk_i);
    chk_val(32'(i_mrs_master_model.rise_cyc), 32'(r), "answer started");
    chk_val(i_mrs_master_model.rx_q.size(), 0, "answer bytes");
  endtask

  // 16-bit read of a 32-bit parameter, index 0 is parameter 0.1
  task automatic t_read16();
    par_log.delete();
    par_rsp_i.is32 = 1'b1;
    par_rsp_i.rdata = 32'h1234ABCD;
    i_mrs_master_model.send_frame('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    expect_resp('{8'h01, 8'h03, 8'h02, 8'hAB, 8'hCD});
    chk_acc(15'h0001);
    $display("read16 done");
  endtask

  // 32-bit read of a 16-bit parameter with bit 15 set, menu 2 parameter 0
  task automatic t_read32();
    par_log.delete();
    par_rsp_i.is32 = 1'b0;
    par_rsp_i.rdata = 32'h00008001;
    i_mrs_master_model.send_frame('{8'h01, 8'h03, 8'hC0, 8'hC7, 8'h00, 8'h02}, 1'b0);
    expect_resp('{8'h01, 8'h03, 8'h04, 8'hFF, 8'hFF, 8'h80, 8'h01});
    chk_acc(15'h0100);
    $display("read32 done");
  endtask

  // broadcast single write: done, sign-extended, never answered
  task automatic t_bcast();
    par_log.delete();
    i_mrs_master_model.send_frame('{8'h00, 8'h06, 8'h00, 8'h09, 8'hFF, 8'hFE}, 1'b0);
    expect_none();
    chk_acc(15'h400A);
    chk_val(par_log[0].wdata, 32'hFFFFFFFE, "write data");
    $display("broadcast done");
  endtask

  // 32-bit multiple write of parameter 0.1, echoed after the write
  task automatic t_wr32();
    logic [7:0] q[$];
    q = '{8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78};
    par_log.delete();
    i_mrs_master_model.send_frame(q, 1'b0);
    expect_resp('{8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'h02});
    chk_acc(15'h4001);
    chk_val(par_log[0].wdata, 32'h12345678, "write data");
    $display("write32 done");
  endtask

  // frame for another node: no access, no answer
  task automatic t_other();
    par_log.delete();
    i_mrs_master_model.send_frame('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    expect_none();
    chk_val(par_log.size(), 0, "access count");
    $display("other node done");
  endtask

  // corrupted check: no access, no answer
  task automatic t_badcrc();
    par_log.delete();
    i_mrs_master_model.send_frame('{8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05}, 1'b1);
    expect_none();
    chk_val(par_log.size(), 0, "access count");
    $display("bad check done");
  endtask

  // read of 17 registers is refused with code 2
  task automatic t_toomany();
    par_log.delete();
    i_mrs_master_model.send_frame('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11}, 1'b0);
    expect_resp('{8'h01, 8'h83, 8'h02});
    chk_val(par_log.size(), 0, "access count");
    $display("limit done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond all seven transactions
  initial begin
    repeat (1500000) @(posedge ref_clk_i);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    t_read16();
    t_read32();
    t_bcast();
    t_wr32();
    t_other();
    t_badcrc();
    t_toomany();
    end_of_test();
  end
endmodule
